// file: design/rcb_reg_bank.sv
// Receiver control register bank with soft reset and staged settings
`timescale 1ns/1ps
module rcb_reg_bank #(
   parameter int DATA_W = rcb_pkg::DATA_W,
   parameter int ADDR_W = rcb_pkg::ADDR_W
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic reg_wr_en_i,
   input wire logic reg_rd_en_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic seg_err_excess_i,
   input wire logic first_byte_raw_i,
   input wire logic error_raw_i,
   input wire logic valid_raw_i,
   input wire logic gain_raw_i,
   output logic acq_restart_o,
   output logic cfg_apply_o,
   output logic redundancy_output_select_o,
   output logic serial_output_select_o,
   output logic output_clock_edge_select_o,
   output logic packet_first_byte_flag_o,
   output logic packet_error_flag_o,
   output logic packet_valid_strobe_o,
   output logic [1:0] demod_type_select_o,
   output logic qam_mode_o,
   output logic spectral_shift_neg_o,
   output logic iq_swap_o,
   output logic cochannel_filter_insert_o,
   output logic cochannel_auto_detect_o,
   output logic adjacent_filter_bypass_o,
   output logic auto_restart_disable_o,
   output logic gain_control_output_o
);

   //==================================================================
   // Parameter checks
   if (DATA_W != 8) begin : g_chk_data
      $error("rcb_reg_bank: DATA_W must be 8");
   end
   if (ADDR_W < 3) begin : g_chk_addr
      $error("rcb_reg_bank: ADDR_W must reach offset 04h");
   end

   //==================================================================
   // Host-visible registers
   logic [7:0] ctrl_ff;
   logic [7:0] front_ff;
   logic [7:0] vsb_ff;
   logic [7:0] gain_ff;

   // Applied copies, loaded from the registers only by a soft reset
   logic [7:0] act_ctrl_ff;
   logic [7:0] act_vsb_ff;
   logic [7:0] act_gain_ff;
   logic shift_neg_ff;
   logic iq_swap_ff;
   logic coch_ins_ff;
   logic coch_auto_ff;
   logic adj_byp_ff;

   logic restart_ff;
   logic apply_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;

   //==================================================================
   // Address decode
   wire [7:0] addr8 = 8'(reg_addr_i);
   wire [7:0] wdata8 = reg_wdata_i[7:0];
   wire hit_ctrl = (addr8 == rcb_pkg::OFS_CTRL);
   wire hit_front = (addr8 == rcb_pkg::OFS_FRONT);
   wire hit_vsb = (addr8 == rcb_pkg::OFS_VSB);
   wire hit_gain = (addr8 == rcb_pkg::OFS_GAIN);
   wire wr_ctrl = ce_i && reg_wr_en_i && hit_ctrl;
   wire wr_front = ce_i && reg_wr_en_i && hit_front;
   wire wr_vsb = ce_i && reg_wr_en_i && hit_vsb;
   wire wr_gain = ce_i && reg_wr_en_i && hit_gain;
   wire soft_reset = wr_ctrl;

   // Stored value after this cycle's write
   wire [7:0] nxt_ctrl = wr_ctrl ? wdata8 : ctrl_ff;
   wire [7:0] nxt_front = wr_front ?
      (wdata8 & rcb_pkg::FRONT_WR_MASK) : front_ff;
   wire [7:0] nxt_vsb = wr_vsb ?
      ((wdata8 & rcb_pkg::VSB_WR_MASK) | rcb_pkg::VSB_FIXED) : vsb_ff;
   wire [7:0] nxt_gain = wr_gain ?
      ((wdata8 & rcb_pkg::GAIN_WR_MASK) | rcb_pkg::GAIN_FIXED) : gain_ff;

   //==================================================================
   // Decode of the settings that a soft reset applies
   wire [1:0] src_demod = nxt_ctrl[rcb_pkg::CTRL_DEMOD_LSB +: 2];
   wire src_qam = (src_demod == rcb_pkg::rcb_qam64) ||
      (src_demod == rcb_pkg::rcb_qam256);
   wire [1:0] src_coch = front_ff[rcb_pkg::FRONT_COCH_LSB +: 2];
   wire src_shift = front_ff[rcb_pkg::FRONT_SHIFT_BIT];
   wire nxt_shift_neg = !src_qam && src_shift;
   wire nxt_iq_swap = src_qam && src_shift;
   wire nxt_coch_ins = !src_qam &&
      (src_coch == rcb_pkg::rcb_coch_insert);
   wire nxt_coch_auto = !src_qam &&
      ((src_coch == rcb_pkg::rcb_coch_auto) ||
       (src_coch == rcb_pkg::rcb_coch_rsvd));
   wire nxt_adj_byp = src_qam ||
      front_ff[rcb_pkg::FRONT_ADJ_BIT];

   // Automatic restart follows the applied disable bit
   wire auto_restart = ce_i && seg_err_excess_i &&
      !act_vsb_ff[rcb_pkg::VSB_AUTO_OFF_BIT];

   //==================================================================
   // Read data select
   wire [7:0] rd_sel = hit_ctrl ? ctrl_ff :
      hit_front ? front_ff :
      hit_vsb ? vsb_ff :
      hit_gain ? gain_ff : rcb_pkg::UNMAPPED_DATA;

   //==================================================================
   // Host-visible registers; soft reset leaves them alone
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ctrl_ff <= rcb_pkg::RST_CTRL;
         front_ff <= rcb_pkg::RST_FRONT;
         vsb_ff <= rcb_pkg::RST_VSB;
         gain_ff <= rcb_pkg::RST_GAIN;
      end else begin
         ctrl_ff <= nxt_ctrl;
         front_ff <= nxt_front;
         vsb_ff <= nxt_vsb;
         gain_ff <= nxt_gain;
      end
   end

   //==================================================================
   // Applied settings
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         act_ctrl_ff <= rcb_pkg::RST_CTRL;
         act_vsb_ff <= rcb_pkg::RST_VSB;
         act_gain_ff <= rcb_pkg::RST_GAIN;
         shift_neg_ff <= 1'b0;
         iq_swap_ff <= 1'b0;
         coch_ins_ff <= 1'b0;
         coch_auto_ff <= 1'b1;
         adj_byp_ff <= 1'b0;
      end else if (soft_reset) begin
         act_ctrl_ff <= nxt_ctrl;
         act_vsb_ff <= vsb_ff;
         act_gain_ff <= gain_ff;
         shift_neg_ff <= nxt_shift_neg;
         iq_swap_ff <= nxt_iq_swap;
         coch_ins_ff <= nxt_coch_ins;
         coch_auto_ff <= nxt_coch_auto;
         adj_byp_ff <= nxt_adj_byp;
      end
   end

   //==================================================================
   // Restart strobes and read answer
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         restart_ff <= 1'b0;
         apply_ff <= 1'b0;
         rdata_ff <= rcb_pkg::UNMAPPED_DATA;
         rvalid_ff <= 1'b0;
      end else if (ce_i) begin
         restart_ff <= soft_reset || auto_restart;
         apply_ff <= soft_reset;
         rvalid_ff <= reg_rd_en_i;
         if (reg_rd_en_i) begin
            rdata_ff <= rd_sel;
         end
      end
   end

   //==================================================================
   // Transport and gain pins with applied polarity
   rcb_pol_stage #(.W(1)) u_byte_pol (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .raw_i(first_byte_raw_i),
      .invert_i(act_ctrl_ff[rcb_pkg::CTRL_BYTE_POL_BIT]),
      .pin_o(packet_first_byte_flag_o)
   );

   rcb_pol_stage #(.W(1)) u_err_pol (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .raw_i(error_raw_i),
      .invert_i(act_ctrl_ff[rcb_pkg::CTRL_ERR_POL_BIT]),
      .pin_o(packet_error_flag_o)
   );

   rcb_pol_stage #(.W(1)) u_pkt_pol (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .raw_i(valid_raw_i),
      .invert_i(act_ctrl_ff[rcb_pkg::CTRL_PKT_POL_BIT]),
      .pin_o(packet_valid_strobe_o)
   );

   rcb_pol_stage #(.W(1)) u_gain_pol (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .raw_i(gain_raw_i),
      .invert_i(act_gain_ff[rcb_pkg::GAIN_INV_BIT]),
      .pin_o(gain_control_output_o)
   );

   //==================================================================
   // Outputs
   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;
   assign acq_restart_o = restart_ff;
   assign cfg_apply_o = apply_ff;
   assign redundancy_output_select_o =
      act_ctrl_ff[rcb_pkg::CTRL_REDUND_BIT];
   assign serial_output_select_o =
      act_ctrl_ff[rcb_pkg::CTRL_SERIAL_BIT];
   assign output_clock_edge_select_o =
      act_ctrl_ff[rcb_pkg::CTRL_EDGE_BIT];
   assign demod_type_select_o =
      act_ctrl_ff[rcb_pkg::CTRL_DEMOD_LSB +: 2];
   assign qam_mode_o = act_ctrl_ff[rcb_pkg::CTRL_DEMOD_LSB + 1];
   assign spectral_shift_neg_o = shift_neg_ff;
   assign iq_swap_o = iq_swap_ff;
   assign cochannel_filter_insert_o = coch_ins_ff;
   assign cochannel_auto_detect_o = coch_auto_ff;
   assign adjacent_filter_bypass_o = adj_byp_ff;
   assign auto_restart_disable_o =
      act_vsb_ff[rcb_pkg::VSB_AUTO_OFF_BIT];

   //==================================================================
   // Checks
   soft_reset_pulse_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && reg_wr_en_i && hit_ctrl) |=>
         (acq_restart_o && cfg_apply_o))
      else $error("soft reset did not pulse restart and apply");

   staged_cfg_hold_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && reg_wr_en_i && !hit_ctrl) |=>
         ($stable(adjacent_filter_bypass_o) &&
          $stable(cochannel_filter_insert_o) &&
          $stable(auto_restart_disable_o) &&
          $stable(spectral_shift_neg_o)))
      else $error("setting took effect without soft reset");

   format_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && reg_wr_en_i && hit_ctrl) |=>
         (redundancy_output_select_o == $past(reg_wdata_i[7])) &&
         (serial_output_select_o == $past(reg_wdata_i[6])) &&
         (output_clock_edge_select_o == $past(reg_wdata_i[5])))
      else $error("output format bits not applied");

   qam_filter_bypass_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      qam_mode_o |-> (adjacent_filter_bypass_o &&
         !cochannel_filter_insert_o && !cochannel_auto_detect_o &&
         !spectral_shift_neg_o))
      else $error("filters not bypassed in QAM mode");

   byte_start_pol_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && $stable(act_ctrl_ff)) |=>
         (packet_first_byte_flag_o == ($past(first_byte_raw_i) ^
          $past(act_ctrl_ff[rcb_pkg::CTRL_BYTE_POL_BIT]))))
      else $error("byte start polarity wrong");

   auto_restart_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && seg_err_excess_i) |=>
         (acq_restart_o == (!$past(auto_restart_disable_o) ||
          $past(soft_reset))))
      else $error("automatic restart mismatch");

   regs_kept_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && reg_wr_en_i && hit_ctrl) |=>
         ($stable(front_ff) && $stable(vsb_ff) && $stable(gain_ff)))
      else $error("soft reset altered a register");

   vsb_read_fixed_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && reg_rd_en_i && hit_vsb) |=>
         (reg_rvalid_o && (reg_rdata_o[3:0] == 4'h2) &&
          (reg_rdata_o[7:5] == 3'h0)))
      else $error("restart register read wrong");

   gain_invert_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ce_i && $stable(act_gain_ff)) |=>
         (gain_control_output_o == ($past(gain_raw_i) ^
          $past(act_gain_ff[rcb_pkg::GAIN_INV_BIT]))))
      else $error("gain output polarity wrong");

   iq_swap_qam_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (soft_reset && src_qam && src_shift) |=>
         (iq_swap_o && !spectral_shift_neg_o))
      else $error("IQ swap not applied in QAM");

   err_pol_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ce_i |=>
         (packet_error_flag_o == ($past(error_raw_i) ^
          $past(act_ctrl_ff[rcb_pkg::CTRL_ERR_POL_BIT]))))
      else $error("data error polarity wrong");

   pkt_pol_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ce_i |=>
         (packet_valid_strobe_o == ($past(valid_raw_i) ^
          $past(act_ctrl_ff[rcb_pkg::CTRL_PKT_POL_BIT]))))
      else $error("packet clock polarity wrong");

   demod_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      soft_reset |=>
         ((demod_type_select_o ==
           $past(reg_wdata_i[rcb_pkg::CTRL_DEMOD_LSB +: 2])) &&
          (qam_mode_o == $past(reg_wdata_i[rcb_pkg::CTRL_DEMOD_LSB + 1]))))
      else $error("demodulation mode not applied");

   coch_vsb_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (soft_reset && !src_qam) |=>
         (cochannel_filter_insert_o ==
          ($past(src_coch) == rcb_pkg::rcb_coch_insert)))
      else $error("co-channel setting not applied in VSB");

   adj_vsb_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (soft_reset && !src_qam) |=>
         (adjacent_filter_bypass_o ==
          $past(front_ff[rcb_pkg::FRONT_ADJ_BIT])))
      else $error("adjacent filter setting not applied");

   restart_off_apply_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      soft_reset |=>
         (auto_restart_disable_o ==
          $past(vsb_ff[rcb_pkg::VSB_AUTO_OFF_BIT])))
      else $error("restart disable not applied");

   ce_freeze_a: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      !ce_i |=>
         ($stable(ctrl_ff) && $stable(gain_ff) && $stable(act_ctrl_ff) &&
          $stable(acq_restart_o) && $stable(reg_rvalid_o)))
      else $error("state changed while clock enable was low");

endmodule

// file: design/rcb_pkg.sv
// Constants, field positions and reset values of the receiver control bank
//=====================================================================
// Operation
// - Any host write to the first register soft-resets into acquisition.
// - Settings in 01h to 04h take effect only at the next soft reset.
// - First register bit 7 selects data only (0) or data with redundancy (1).
// - First register bit 6 selects 8-bit parallel (0) or serial (1) output.
// - Bit 5 selects rising (0) or falling (1, default) output clock edge.
// - Bit 4 makes the byte-start output active high (0) or active low (1).
// - Bit 3 makes the data-error output active high (0) or active low (1).
// - Bit 2 makes the packet-clock output active high (0) or active low (1).
// - Demod field 00 is 8-level VSB, 10 is 64-QAM, 11 is 256-QAM; 01 unused.
// - Front-end bit 5 picks negative spectral shift; in QAM swaps I and Q.
// - Co-channel 00 auto, 01 bypass, 10 insert, 11 reserved; off in QAM.
// - Front-end bit 1 bypasses adjacent channel filter; always in QAM.
// - Restart-disable 0 restarts on segment errors; 1 suppresses it.
// - Gain register bit 2 inverts the gain-control output (default inverted).
//=====================================================================
package rcb_pkg;

   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;

   //==================================================================
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FRONT = 8'h01;
   localparam logic [7:0] OFS_VSB = 8'h03;
   localparam logic [7:0] OFS_GAIN = 8'h04;

   //==================================================================
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h20;
   localparam logic [7:0] RST_FRONT = 8'h11;
   localparam logic [7:0] RST_VSB = 8'h02;
   localparam logic [7:0] RST_GAIN = 8'h07;

   //==================================================================
   // Writable bits and fixed read values
   localparam logic [7:0] FRONT_WR_MASK = 8'h3f;
   localparam logic [7:0] VSB_WR_MASK = 8'h10;
   localparam logic [7:0] VSB_FIXED = 8'h02;
   localparam logic [7:0] GAIN_WR_MASK = 8'h04;
   localparam logic [7:0] GAIN_FIXED = 8'h03;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   //==================================================================
   // Field positions
   localparam int CTRL_REDUND_BIT = 7;
   localparam int CTRL_SERIAL_BIT = 6;
   localparam int CTRL_EDGE_BIT = 5;
   localparam int CTRL_BYTE_POL_BIT = 4;
   localparam int CTRL_ERR_POL_BIT = 3;
   localparam int CTRL_PKT_POL_BIT = 2;
   localparam int CTRL_DEMOD_LSB = 0;
   localparam int FRONT_SHIFT_BIT = 5;
   localparam int FRONT_COCH_LSB = 2;
   localparam int FRONT_ADJ_BIT = 1;
   localparam int VSB_AUTO_OFF_BIT = 4;
   localparam int GAIN_INV_BIT = 2;

   //==================================================================
   // Field encodings
   typedef enum logic [1:0] {
      rcb_vsb8 = 2'b00,
      rcb_demod_rsvd = 2'b01,
      rcb_qam64 = 2'b10,
      rcb_qam256 = 2'b11
   } rcb_demod_t;

   typedef enum logic [1:0] {
      rcb_coch_auto = 2'b00,
      rcb_coch_bypass = 2'b01,
      rcb_coch_insert = 2'b10,
      rcb_coch_rsvd = 2'b11
   } rcb_coch_t;

endpackage

// file: design/rcb_pol_stage.sv
// Registered output stage with selectable polarity
`timescale 1ns/1ps
module rcb_pol_stage #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] raw_i,
   input wire logic invert_i,
   output logic [W-1:0] pin_o
);

   logic [W-1:0] pin_ff;
   wire [W-1:0] nxt_pin = raw_i ^ {W{invert_i}};

   if (W < 1) begin : g_chk
      $error("rcb_pol_stage: W must be at least 1");
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pin_ff <= '0;
      end else if (ce_i) begin
         pin_ff <= nxt_pin;
      end
   end

   assign pin_o = pin_ff;

endmodule

// file: sim/rcb_host_model.sv
// Host processor model driving the register port of the control bank
`timescale 1ns/1ps
module rcb_host_model (
   input wire logic ref_clk_i,
   output logic wr_en_o,
   output logic rd_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i
);
   initial begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   //==================================================================
   // Enables drop to 0; address and data lines show the inverse of the last value
   task automatic release_bus();
      @(negedge ref_clk_i);
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = ~addr_o;
      wdata_o = ~wdata_o;
   endtask

   //==================================================================
   // Write one register with its fixed bits forced to the legal values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h01) begin
         v = v | 8'h11;
      end
      if (a == 8'h01 && v[3:2] == 2'b11) begin
         v[3:2] = 2'b00;
      end
      if (a == 8'h03) begin
         v = {v[7:4], 4'h2};
      end
      if (a == 8'h04) begin
         v = {v[7:2], 2'h3};
      end
      if (a == 8'h00 && v[1:0] == 2'b01) begin
         v[1:0] = 2'b00;
      end
      @(negedge ref_clk_i);
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = v;
      @(posedge ref_clk_i);
      release_bus();
   endtask

   //==================================================================
   // Read one register; the answer stands in the cycle after the request
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(negedge ref_clk_i);
      rd_en_o = 1'b1;
      addr_o = a;
      @(posedge ref_clk_i);
      release_bus();
      d = rdata_i;
      v = rvalid_i;
   endtask
endmodule

// file: sim/receiver_control_register_bank_test.sv
// Self-checking testbench of the receiver control register bank
`timescale 1ns/1ps
module receiver_control_register_bank_test;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce = 1'b1;
   logic seg = 1'b0;
   logic fb = 1'b0;
   logic er = 1'b0;
   logic vl = 1'b0;
   logic gn = 1'b0;
   logic wr_en, rd_en, rvalid, acq, apply, redund, serial, edge_sel;
   logic fbo, ero, vlo, qam, sneg, iqs, cins, cauto, adjb, ard, gno;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] demod;
   logic [1:0] code;
   logic q;
   int err_total = 0;
   int cmp_count = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   rcb_reg_bank dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce),
      .reg_wr_en_i(wr_en), .reg_rd_en_i(rd_en), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .seg_err_excess_i(seg), .first_byte_raw_i(fb), .error_raw_i(er),
      .valid_raw_i(vl), .gain_raw_i(gn), .acq_restart_o(acq),
      .cfg_apply_o(apply), .redundancy_output_select_o(redund),
      .serial_output_select_o(serial),
      .output_clock_edge_select_o(edge_sel),
      .packet_first_byte_flag_o(fbo), .packet_error_flag_o(ero),
      .packet_valid_strobe_o(vlo), .demod_type_select_o(demod),
      .qam_mode_o(qam), .spectral_shift_neg_o(sneg), .iq_swap_o(iqs),
      .cochannel_filter_insert_o(cins), .cochannel_auto_detect_o(cauto),
      .adjacent_filter_bypass_o(adjb), .auto_restart_disable_o(ard),
      .gain_control_output_o(gno));

   rcb_host_model host (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en),
      .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata),
      .rvalid_i(rvalid));

   //==================================================================
   // Checking and reporting
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got,
                  exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      chk({7'h0, v}, 8'h01);
      chk(d, exp);
   endtask

   task automatic polchk(input logic p, input logic g);
      for (int r = 0; r < 2; r++) begin
         @(negedge ref_clk_i);
         fb = r[0];
         er = ~r[0];
         vl = r[0];
         gn = ~r[0];
         @(negedge ref_clk_i);
         chk({4'h0, fbo, ero, vlo, gno},
         {4'h0, r[0] ^ p, ~r[0] ^ p, r[0] ^ p, ~r[0] ^ g});
      end
   endtask

   // One excess-error pulse, then the restart and apply pulses
   task automatic segchk(input logic [1:0] exp);
      @(negedge ref_clk_i);
      seg = 1'b1;
      @(negedge ref_clk_i);
      seg = 1'b0;
      chk({6'h0, acq, apply}, {6'h0, exp});
   endtask

   task automatic done(input string n);
      $display("test %s finished, mismatches so far %0d", n, err_total);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The tests need well under 1000 cycles
   initial begin
      #200000;
      err_total++;
      conclude();
   end

   //==================================================================
   // Test sequence
   initial begin
      repeat (6) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      rdchk(8'h00, 8'h20);
      rdchk(8'h01, 8'h11);
      rdchk(8'h03, 8'h02);
      rdchk(8'h04, 8'h07);
      rdchk(8'h02, 8'h00);
      chk({6'h0, edge_sel, cauto}, 8'h03);
      done("reset values");
      host.wr(8'h01, 8'h2a);
      host.wr(8'h03, 8'h10);
      host.wr(8'h04, 8'h00);
      chk({5'h0, adjb, cins, ard}, 8'h00);
      host.wr(8'h00, 8'hdc);
      chk({6'h0, acq, apply}, 8'h03);
      chk({redund, serial, edge_sel, sneg, cins, adjb, ard, qam},
          8'hde);
      @(negedge ref_clk_i);
      chk({6'h0, acq, apply}, 8'h00);
      rdchk(8'h00, 8'hdc);
      rdchk(8'h01, 8'h3b);
      rdchk(8'h03, 8'h12);
      rdchk(8'h04, 8'h03);
      done("staged settings");
      polchk(1'b1, 1'b0);
      host.wr(8'h04, 8'h04);
      host.wr(8'h00, 8'h20);
      polchk(1'b0, 1'b1);
      done("output polarity");
      host.wr(8'h01, 8'h20);
      for (int i = 0; i < 3; i++) begin
         code = (i == 0) ? 2'b00 : ((i == 1) ? 2'b10 : 2'b11);
         q = code[1];
         host.wr(8'h00, {6'h08, code});
         chk({6'h0, demod}, {6'h0, code});
         chk({2'b0, qam, sneg, iqs, cins, cauto, adjb},
             {2'b0, q, ~q, q, 1'b0, ~q, q});
      end
      for (int c = 0; c < 3; c++) begin
         host.wr(8'h01, {4'h0, c[1:0], 2'b00});
         host.wr(8'h00, 8'h20);
         chk({5'h0, cins, cauto, adjb},
             {5'h0, c == 2, c == 0, 1'b0});
      end
      done("demod and filters");
      segchk(2'b00);
      host.wr(8'h03, 8'h00);
      segchk(2'b00);
      host.wr(8'h00, 8'h20);
      segchk(2'b10);
      done("auto restart");
      @(negedge ref_clk_i);
      ce = 1'b0;
      host.wr(8'h04, 8'h00);
      segchk(2'b00);
      ce = 1'b1;
      rdchk(8'h04, 8'h07);
      done("clock enable");
      conclude();
   end
endmodule
